//--- rtl/csf_pkg.sv
package csf_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [6:0] CSF_STATUS_ADDR = 7'h03;
  localparam int CSF_ADDR_W = 7;

  // ------------------------------------------------------------
  // field positions in the status word
  // ------------------------------------------------------------
  localparam int CSF_BIT_C = 0;
  localparam int CSF_BIT_DC = 1;
  localparam int CSF_BIT_Z = 2;
  localparam int CSF_BIT_PD = 3;
  localparam int CSF_BIT_TO = 4;
  localparam int CSF_BIT_PAGE_LO = 5;
  localparam int CSF_BIT_SPARE = 7;

  // ------------------------------------------------------------
  // values after reset and paging
  // ------------------------------------------------------------
  // zero, nibble and carry flag bits are undefined at power-up; zero chosen
  localparam logic [7:0] CSF_STATUS_RESET = 8'h18;
  localparam logic [7:0] CSF_READ_MISS = 8'h00;
  localparam int CSF_PAGE_WORDS_LOG2 = 9;
  localparam int CSF_PROG_ADDR_W = 11;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic spare_page_bit;
    logic [1:0] page_select;
    logic watchdog_expired_n;
    logic sleep_entered_n;
    logic zero_flag;
    logic nibble_half_flag;
    logic carry_flag;
  } csf_status_t;

  // which flags the executing instruction computes
  typedef enum logic [2:0] {
    CSF_FOP_NONE = 3'h0,
    CSF_FOP_ZERO = 3'h1,
    CSF_FOP_ADD = 3'h2,
    CSF_FOP_SUB = 3'h3,
    CSF_FOP_ROTR = 3'h4,
    CSF_FOP_ROTL = 3'h5
  } csf_flag_op_t;

  typedef struct packed {
    logic valid;
    csf_flag_op_t flag_op;
    logic [7:0] file_operand;
    logic [7:0] work_operand;
    logic [7:0] logic_result;
  } csf_exec_t;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } csf_wr_t;

endpackage : csf_pkg

//--- rtl/csf_status_reg.sv
// What this block does
// [RQ1] status word lives at file address 03h and reads/writes like any file register
// [RQ2] instruction writes to zero, nibble and carry flags lose to flag logic
// [RQ3] instruction writes to watchdog-expired and sleep-entered flags are ignored
// [RQ4] clearing the status word zeroes upper three bits and sets zero flag
// [RQ5] software should alter the word only with bit set, bit clear, move
// [RQ6] bit 7 has no function; software should not use it as storage
// [RQ7] page_select picks one of four 512-word program pages
// [RQ8] without paging, software should not use page_select as general storage
// [RQ9] watchdog-expired reads 1 after power-up, kick, sleep; 0 on watchdog timeout
// [RQ10] sleep-entered reads 1 after power-up or kick; 0 after sleep
// [RQ11] zero flag set when operation result is zero, else cleared
// [RQ12] add: nibble flag is carry out of result bit 3
// [RQ13] subtract: nibble flag is inverted borrow from bit 3
// [RQ14] carry flag is add carry out, or subtract inverted borrow
// [RQ15] rotate right/left loads carry with operand lsb/msb
// [RQ16] flag updates and data write land together at end of the cycle
module csf_status_reg (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // instruction execution
  input wire csf_pkg::csf_exec_t exec_in,
  input wire csf_pkg::csf_wr_t file_wr_in,
  // file read port
  input wire logic [csf_pkg::CSF_ADDR_W-1:0] file_rd_addr_in,
  output logic [7:0] file_rd_data_out,
  // power management and watchdog events
  input wire logic watchdog_kick_in,
  input wire logic sleep_exec_in,
  input wire logic watchdog_timeout_in,
  // status toward the core
  output csf_pkg::csf_status_t status_out,
  output logic [csf_pkg::CSF_PROG_ADDR_W-1:0] page_base_out
);
  import csf_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  csf_status_t status_reg;
  csf_status_t status_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic [csf_pkg::CSF_PROG_ADDR_W-1:0] page_base_reg;
  logic [csf_pkg::CSF_PROG_ADDR_W-1:0] page_base_next;

  // ------------------------------------------------------------
  // arithmetic flag calculation
  // ------------------------------------------------------------
  logic [7:0] add_sum;
  logic add_c;
  logic add_dc;
  logic [7:0] sub_diff;
  logic sub_c;
  logic sub_dc;
  logic flag_z_new;
  logic flag_dc_new;
  logic flag_c_new;
  logic upd_z;
  logic upd_dc;
  logic upd_c;

  // subtract runs as f + ~w + 1, so each carry out is the inverted borrow
  csf_carry_add #(
    .WIDTH(8)
  ) i_add_full (
    .a_in(exec_in.file_operand),
    .b_in(exec_in.work_operand),
    .carry_in(1'b0),
    .sum_out(add_sum),
    .carry_out(add_c)
  );

  csf_carry_add #(
    .WIDTH(4)
  ) i_add_nib (
    .a_in(exec_in.file_operand[3:0]),
    .b_in(exec_in.work_operand[3:0]),
    .carry_in(1'b0),
    .sum_out(),
    .carry_out(add_dc)
  );

  csf_carry_add #(
    .WIDTH(8)
  ) i_sub_full (
    .a_in(exec_in.file_operand),
    .b_in(~exec_in.work_operand),
    .carry_in(1'b1),
    .sum_out(sub_diff),
    .carry_out(sub_c)
  );

  csf_carry_add #(
    .WIDTH(4)
  ) i_sub_nib (
    .a_in(exec_in.file_operand[3:0]),
    .b_in(~exec_in.work_operand[3:0]),
    .carry_in(1'b1),
    .sum_out(),
    .carry_out(sub_dc)
  );

  always_comb begin
    flag_z_new = 1'b0;
    flag_dc_new = 1'b0;
    flag_c_new = 1'b0;
    upd_z = 1'b0;
    upd_dc = 1'b0;
    upd_c = 1'b0;
    if (exec_in.valid) begin
      unique case (exec_in.flag_op)
        CSF_FOP_NONE: begin
        end
        CSF_FOP_ZERO: begin
          upd_z = 1'b1;
          flag_z_new = (exec_in.logic_result == 8'h00); // RQ11
        end
        CSF_FOP_ADD: begin
          upd_z = 1'b1;
          upd_dc = 1'b1;
          upd_c = 1'b1;
          flag_z_new = (add_sum == 8'h00); // RQ11
          flag_dc_new = add_dc; // RQ12
          flag_c_new = add_c; // RQ14
        end
        CSF_FOP_SUB: begin
          upd_z = 1'b1;
          upd_dc = 1'b1;
          upd_c = 1'b1;
          flag_z_new = (sub_diff == 8'h00); // RQ11
          flag_dc_new = sub_dc; // RQ13
          flag_c_new = sub_c; // RQ14
        end
        CSF_FOP_ROTR: begin
          upd_c = 1'b1;
          flag_c_new = exec_in.file_operand[0]; // RQ15
        end
        CSF_FOP_ROTL: begin
          upd_c = 1'b1;
          flag_c_new = exec_in.file_operand[7]; // RQ15
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // next status word
  // ------------------------------------------------------------
  logic wr_hit;
  logic upd_any;
  csf_status_t wr_word;

  always_comb begin
    wr_hit = file_wr_in.en && (file_wr_in.addr == CSF_STATUS_ADDR); // RQ1
    upd_any = upd_z || upd_dc || upd_c;
    wr_word = csf_status_t'(file_wr_in.data);
    // sleep/watchdog flags are never taken from the data
    status_next = status_reg; // RQ3
    if (wr_hit) begin
      status_next.spare_page_bit = wr_word.spare_page_bit; // RQ1 RQ4
      status_next.page_select = wr_word.page_select; // RQ4 RQ7
      // any flag-updating op locks all three arithmetic bits, not only its own
      if (!upd_any) begin
        status_next.zero_flag = wr_word.zero_flag; // RQ2
        status_next.nibble_half_flag = wr_word.nibble_half_flag; // RQ2
        status_next.carry_flag = wr_word.carry_flag; // RQ2
      end
    end
    // flag logic overrides the data write in the same cycle
    if (upd_z) begin
      status_next.zero_flag = flag_z_new; // RQ2 RQ16
    end
    if (upd_dc) begin
      status_next.nibble_half_flag = flag_dc_new; // RQ2 RQ16
    end
    if (upd_c) begin
      status_next.carry_flag = flag_c_new; // RQ2 RQ16
    end
    // kick first, sleep next, timeout last so a timeout is never masked
    if (watchdog_kick_in) begin
      status_next.watchdog_expired_n = 1'b1; // RQ9
      status_next.sleep_entered_n = 1'b1; // RQ10
    end
    if (sleep_exec_in) begin
      status_next.watchdog_expired_n = 1'b1; // RQ9
      status_next.sleep_entered_n = 1'b0; // RQ10
    end
    if (watchdog_timeout_in) begin
      status_next.watchdog_expired_n = 1'b0; // RQ9
    end
  end

  // ------------------------------------------------------------
  // read port, one cycle latency, shows the updated word
  // ------------------------------------------------------------
  always_comb begin
    page_base_next = {status_next.page_select, {CSF_PAGE_WORDS_LOG2{1'b0}}}; // RQ7
    if (file_rd_addr_in == CSF_STATUS_ADDR) begin
      rd_data_next = status_next; // RQ1 RQ16
    end else begin
      rd_data_next = CSF_READ_MISS;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_reg <= csf_status_t'(CSF_STATUS_RESET); // RQ9 RQ10
      rd_data_reg <= CSF_READ_MISS;
      page_base_reg <= {CSF_STATUS_RESET[CSF_BIT_PAGE_LO+1:CSF_BIT_PAGE_LO],
        {CSF_PAGE_WORDS_LOG2{1'b0}}};
    end else begin
      status_reg <= status_next;
      rd_data_reg <= rd_data_next;
      page_base_reg <= page_base_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign status_out = status_reg;
  assign file_rd_data_out = rd_data_reg;
  // own flop so the page base never waits on a decode after the status word
  assign page_base_out = page_base_reg; // RQ7

endmodule : csf_status_reg

// ------------------------------------------------------------
// carry-out adder shared by the add and subtract paths
// ------------------------------------------------------------
module csf_carry_add #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic carry_in,
  // result
  output logic [WIDTH-1:0] sum_out,
  output logic carry_out
);

  logic [WIDTH:0] total;

  always_comb begin
    total = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, carry_in};
    sum_out = total[WIDTH-1:0];
    carry_out = total[WIDTH];
  end

endmodule : csf_carry_add

//--- bench/csf_status_reg_properties.sv
module csf_status_reg_properties (
  // watched ports
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire csf_pkg::csf_exec_t exec_in,
  input wire csf_pkg::csf_wr_t file_wr_in,
  input wire logic [csf_pkg::CSF_ADDR_W-1:0] file_rd_addr_in,
  input wire logic [7:0] file_rd_data_out,
  input wire logic watchdog_kick_in,
  input wire logic sleep_exec_in,
  input wire logic watchdog_timeout_in,
  input wire csf_pkg::csf_status_t status_out,
  input wire logic [csf_pkg::CSF_PROG_ADDR_W-1:0] page_base_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic [7:0] f = exec_in.file_operand;
  wire logic [7:0] w = exec_in.work_operand;
  wire logic [8:0] a9 = f + w;
  wire logic [4:0] a5 = f[3:0] + w[3:0];
  wire logic [8:0] s9 = f - w;
  wire logic [4:0] s5 = f[3:0] - w[3:0];
  wire logic [2:0] op = exec_in.flag_op;
  wire logic go = exec_in.valid;
  wire logic hit = file_wr_in.en && file_wr_in.addr == CSF_STATUS_ADDR;
  wire logic quiet = !(watchdog_kick_in || sleep_exec_in || watchdog_timeout_in);
  wire logic [2:0] add_f = {a9[7:0] == 8'h00, a5[4], a9[8]};
  wire logic [2:0] sub_f = {s9[7:0] == 8'h00, !s5[4], !s9[8]};
  wire logic rot_c = (op == CSF_FOP_ROTR) ? f[0] : f[7];
  wire logic [5:0] wr_bits = {file_wr_in.data[7:5], file_wr_in.data[2:0]};
  wire logic [5:0] st_bits = {status_out[7:5], status_out[2:0]};
  wire logic [1:0] rst_f = status_out[4:3];
  wire logic [1:0] ar_f = status_out[1:0];
  property p_read;
    1'b1 |=> file_rd_data_out ==
      ($past(file_rd_addr_in) == CSF_STATUS_ADDR ? status_out : 8'h00);
  endproperty
  a_read: assert property (p_read) else $error("bad read data");
  property p_page; page_base_out == {status_out.page_select, 9'h000}; endproperty
  a_page: assert property (p_page) else $error("bad page base");
  property p_keep; quiet |=> rst_f == $past(rst_f); endproperty
  a_keep: assert property (p_keep) else $error("reset flags moved");
  property p_tmo; watchdog_timeout_in |=> !status_out.watchdog_expired_n; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not flagged");
  property p_add;
    go && op == CSF_FOP_ADD |=> status_out[2:0] == $past(add_f);
  endproperty
  a_add: assert property (p_add) else $error("bad add flags");
  property p_sub;
    go && op == CSF_FOP_SUB |=> status_out[2:0] == $past(sub_f);
  endproperty
  a_sub: assert property (p_sub) else $error("bad subtract flags");
  property p_wr;
    hit && !go |=> st_bits == $past(wr_bits);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_clr;
    hit && file_wr_in.data == 8'h00 && go && op == CSF_FOP_ZERO && exec_in.logic_result == 8'h00
      |=> status_out[7:5] == 3'h0 && status_out.zero_flag && ar_f == $past(ar_f);
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_rot;
    go && (op == CSF_FOP_ROTR || op == CSF_FOP_ROTL) |=> status_out.carry_flag == $past(rot_c);
  endproperty
  a_rot: assert property (p_rot) else $error("bad rotate carry");
  property p_slp;
    sleep_exec_in && !watchdog_timeout_in
      |=> status_out.watchdog_expired_n && !status_out.sleep_entered_n;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep not flagged");
  property p_kick;
    watchdog_kick_in && !sleep_exec_in && !watchdog_timeout_in
      |=> status_out.watchdog_expired_n && status_out.sleep_entered_n;
  endproperty
  a_kick: assert property (p_kick) else $error("kick not flagged");
  c_wr: cover property (hit && !go);
  c_clr: cover property (hit && go);
  c_tmo: cover property (watchdog_timeout_in);
endmodule : csf_status_reg_properties

//--- bench/csf_core_model.sv
module csf_core_model (
  // clock
  input wire logic clk_in,
  // toward the status word
  output csf_pkg::csf_exec_t exec_out,
  output csf_pkg::csf_wr_t wr_out,
  output logic [6:0] rd_addr_out,
  output logic [2:0] ev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  initial {exec_out, wr_out, rd_addr_out, ev_out} = '0;
  // released fields flip so a stale value never looks valid
  task drive(input csf_exec_t e, input csf_wr_t w, input logic [2:0] ev);
    @(negedge clk_in);
    exec_out = e;
    wr_out = {w.en, w.addr, 1'b0, w.data[6:0]};
    ev_out = ev;
    @(negedge clk_in);
    exec_out = {1'b0, e.flag_op, ~e[23:0]};
    wr_out = {1'b0, ~w[14:0]};
    ev_out = 3'h0;
  endtask : drive
  task rd(input logic [6:0] a);
    @(negedge clk_in);
    rd_addr_out = a;
    @(negedge clk_in);
  endtask : rd
endmodule : csf_core_model

//--- bench/test_core_status_flags_register.sv
module test_core_status_flags_register;
  timeunit 1ns;
  timeprecision 1ps;
  import csf_pkg::*;
  localparam logic [6:0] A = CSF_STATUS_ADDR;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  csf_exec_t exec_in;
  csf_wr_t file_wr_in;
  logic [6:0] file_rd_addr_in;
  logic [2:0] ev;
  logic [7:0] file_rd_data_out;
  csf_status_t status_out;
  logic [10:0] page_base_out;
  int n_errors = 0;
  int num_checks = 0;
  initial forever #10 clk_in = ~clk_in;
  csf_core_model i_core (.clk_in(clk_in), .exec_out(exec_in), .wr_out(file_wr_in),
    .rd_addr_out(file_rd_addr_in), .ev_out(ev));
  csf_status_reg i_dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .exec_in(exec_in),
    .file_wr_in(file_wr_in),
    .file_rd_addr_in(file_rd_addr_in),
    .file_rd_data_out(file_rd_data_out),
    .watchdog_kick_in(ev[2]),
    .sleep_exec_in(ev[1]),
    .watchdog_timeout_in(ev[0]),
    .status_out(status_out),
    .page_base_out(page_base_out)
  );
  task check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task op(input csf_exec_t e, input csf_wr_t w, input logic [2:0] v, input logic [7:0] exp);
    i_core.drive(e, w, v);
    check("status", {3'h0, status_out}, {3'h0, exp});
  endtask : op
  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(negedge clk_in);
    check("reset", {3'h0, status_out}, 11'h018);
    check("reset page", page_base_out, 11'h000);
    rst_b_in = 1'b1;
    for (int p = 0; p < 4; p++) begin
      op('0, {1'b1, A, 1'b0, 2'(p), 5'h07}, 3'h0, {1'b0, 2'(p), 5'h1F});
      check("page", page_base_out, {2'(p), 9'h000});
    end
    i_core.rd(A);
    check("read", {3'h0, file_rd_data_out}, 11'h07F);
    i_core.rd(7'h05);
    check("miss", {3'h0, file_rd_data_out}, 11'h000);
    op({1'b1, CSF_FOP_ADD, 16'h0F01, 8'h00}, {1'b1, A, 8'h07}, 3'h0, 8'h1A);
    op({1'b1, CSF_FOP_ADD, 16'hF808, 8'h00}, '0, 3'h0, 8'h1F);
    op({1'b1, CSF_FOP_SUB, 16'h0001, 8'h00}, '0, 3'h0, 8'h18);
    op({1'b1, CSF_FOP_SUB, 16'h1001, 8'h00}, '0, 3'h0, 8'h19);
    op({1'b1, CSF_FOP_ROTR, 16'h0200, 8'h00}, '0, 3'h0, 8'h18);
    op({1'b1, CSF_FOP_ROTL, 16'h8000, 8'h00}, '0, 3'h0, 8'h19);
    op('0, {1'b1, A, 8'h63}, 3'h0, 8'h7B);
    op({1'b1, CSF_FOP_ZERO, 16'h0000, 8'h00}, {1'b1, A, 8'h00}, 3'h0, 8'h1F);
    op({1'b1, CSF_FOP_ZERO, 16'h0000, 8'h5A}, '0, 3'h0, 8'h1B);
    op('0, '0, 3'h1, 8'h0B);
    op('0, {1'b1, A, 8'h1B}, 3'h0, 8'h0B);
    op('0, '0, 3'h2, 8'h13);
    op('0, '0, 3'h4, 8'h1B);
    op('0, '0, 3'h1, 8'h0B);
    rst_b_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("reset again", {3'h0, status_out}, 11'h018);
    check("reset read", {3'h0, file_rd_data_out}, 11'h000);
    rst_b_in = 1'b1;
    op('0, {1'b1, A, 8'h47}, 3'h0, 8'h5F);
    check("page after reset", page_base_out, 11'h400);
    stop_test();
  end
endmodule : test_core_status_flags_register
bind csf_status_reg csf_status_reg_properties i_props (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .exec_in(exec_in),
  .file_wr_in(file_wr_in),
  .file_rd_addr_in(file_rd_addr_in),
  .file_rd_data_out(file_rd_data_out),
  .watchdog_kick_in(watchdog_kick_in),
  .sleep_exec_in(sleep_exec_in),
  .watchdog_timeout_in(watchdog_timeout_in),
  .status_out(status_out),
  .page_base_out(page_base_out)
);
